/* wdar_map.svh */
// Constants for the watchdog answer and off-state cause registers
`ifndef WDAR_MAP_SVH
`define WDAR_MAP_SVH
`define WDAR_STAT_EARLY_BIT   0
`define WDAR_EARLY_RST        1'h0
`define WDAR_ANSWER_RST       8'h00
`define WDAR_CAUSE_RST        8'h00
`define WDAR_MULTI_COUNT      3'h4
`define WDAR_CAUSE_STARTUP    7
`define WDAR_CAUSE_ERRCNT     6
`define WDAR_CAUSE_INPUT_OVERVOLTAGE_CAUSE     5
`define WDAR_CAUSE_REG_FAIL   4
`define WDAR_CAUSE_CRC        3
`define WDAR_CAUSE_RST_TO     2
`define WDAR_CAUSE_SYSCLK     1
`define WDAR_CAUSE_POR        0
`endif

/* wdar_pkg.sv */
// Types for the watchdog answer and off-state cause registers
`default_nettype none
package wdar_pkg;
  typedef struct packed {
    logic       early_answer_flag;
    logic [2:0] resp_count;
    logic [7:0] watchdog_answer_byte;
    logic       answer_strobe;
    logic [7:0] off_state_cause_latch;
  } wdar_state_t;

  typedef struct packed {
    logic startup_timeout_cause;
    logic error_count_powerdown_cause;
    logic input_overvoltage_cause;
    logic regulator_failure_cause;
    logic config_memory_checksum_cause;
    logic reset_state_timeout_cause;
    logic system_clock_failure_cause;
    logic power_on_reset_cause;
  } wdar_cause_t;
endpackage : wdar_pkg
`default_nettype wire

/* wdar_regs.sv */
// Early-answer flag, answer register and off-state cause latch
`timescale 1ns/1ns
`default_nettype none
`include "wdar_map.svh"

// Functional notes
// - Early flag re-evaluated each cycle end, read-clear
// - Multi-answer mode: four answers in window one
// - Single-answer mode: one answer in closed window
// - Answer register initialised on reset and reset-state
// - Cause register zero at power-on, read clears
// - Bit 7 start-up timeout
// - Bit 6 error counter over power-down threshold
// - Bit 5 input overvoltage, latched until read clears it
// - Bit 4 any regulator failure
// - Bit 3 configuration memory checksum error
// - Bit 2 reset state timeout
// - Bit 1 system clock failure by monitor
// - Bit 0 power-on reset event
module wdar_regs (
  // Clock and reset
  input  wire logic               sys_clk,
  input  wire logic               reset_n,
  // Device state
  input  wire logic               reset_state,
  input  wire logic               watchdog_mode_select,
  // Watchdog timing
  input  wire logic               resp_window1,
  input  wire logic               close_window,
  input  wire logic               cycle_end,
  // Serial command decode
  input  wire logic               answer_write_command,
  input  wire logic [7:0]         answer_byte_field,
  input  wire logic               status_read,
  input  wire logic               cause_read,
  input  wire logic               answer_read,
  // Off-state cause events
  input  wire wdar_pkg::wdar_cause_t cause_event,
  // Register outputs
  output logic                    early_answer_flag,
  output logic [7:0]              watchdog_answer_byte,
  output logic                    answer_strobe,
  output logic [7:0]              off_state_cause_latch,
  output logic [7:0]              answer_read_data
);

  wdar_pkg::wdar_state_t st;
  wdar_pkg::wdar_state_t next_st;
  logic                  in_window;
  logic                  early_now;
  logic                  answer_counted;
  logic [3:0]            resp_total;

  always_comb begin
    next_st = st;
    next_st.answer_strobe = 1'b0;
    in_window = watchdog_mode_select ? close_window : resp_window1;
    answer_counted = answer_write_command && in_window;
    // Counting answers in the window that matters for the mode
    if (cycle_end) begin
      next_st.resp_count = 3'h0;
    end else if (answer_write_command && in_window &&
                 st.resp_count != 3'h7) begin
      next_st.resp_count = st.resp_count + 3'h1;
    end
    // Including an answer arriving in the final cycle
    resp_total = {1'b0, st.resp_count} + {3'h0, answer_counted};
    early_now = watchdog_mode_select ?
                (resp_total != 4'h0) :
                (resp_total >= {1'b0, `WDAR_MULTI_COUNT});
    if (status_read) begin
      next_st.early_answer_flag = 1'b0;
    end
    if (cycle_end) begin
      next_st.early_answer_flag = early_now;
    end
    if (answer_write_command) begin
      next_st.watchdog_answer_byte = answer_byte_field;
      next_st.answer_strobe = 1'b1;
    end
    if (reset_state) begin
      next_st.watchdog_answer_byte = `WDAR_ANSWER_RST;
    end
    if (cause_read) begin
      next_st.off_state_cause_latch = `WDAR_CAUSE_RST;
    end
    // Set wins over the read clear
    next_st.off_state_cause_latch[`WDAR_CAUSE_STARTUP] |=
      cause_event.startup_timeout_cause;
    next_st.off_state_cause_latch[`WDAR_CAUSE_ERRCNT] |=
      cause_event.error_count_powerdown_cause;
    next_st.off_state_cause_latch[`WDAR_CAUSE_INPUT_OVERVOLTAGE_CAUSE] |=
      cause_event.input_overvoltage_cause;
    next_st.off_state_cause_latch[`WDAR_CAUSE_REG_FAIL] |=
      cause_event.regulator_failure_cause;
    next_st.off_state_cause_latch[`WDAR_CAUSE_CRC] |=
      cause_event.config_memory_checksum_cause;
    next_st.off_state_cause_latch[`WDAR_CAUSE_RST_TO] |=
      cause_event.reset_state_timeout_cause;
    next_st.off_state_cause_latch[`WDAR_CAUSE_SYSCLK] |=
      cause_event.system_clock_failure_cause;
    next_st.off_state_cause_latch[`WDAR_CAUSE_POR] |=
      cause_event.power_on_reset_cause;
  end

  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      st.early_answer_flag     <= `WDAR_EARLY_RST;
      st.resp_count            <= 3'h0;
      st.watchdog_answer_byte  <= `WDAR_ANSWER_RST;
      st.answer_strobe         <= 1'b0;
      st.off_state_cause_latch <= `WDAR_CAUSE_RST;
    end else begin
      st <= next_st;
    end
  end

  assign early_answer_flag     = st.early_answer_flag;
  assign watchdog_answer_byte  = st.watchdog_answer_byte;
  assign answer_strobe         = st.answer_strobe;
  assign off_state_cause_latch = st.off_state_cause_latch;
  assign answer_read_data      = 8'h00;

  // Cause bits: cause_event packs bits 7..0 in order

  property p_cause_set;
    @(posedge sys_clk) disable iff (!reset_n)
    cause_event != 8'h00 |=> (off_state_cause_latch & $past(cause_event))
                             == $past(cause_event);
  endproperty
  a_cause_set: assert property (p_cause_set)
    else $error("cause event not latched");

  property p_cause_clear;
    @(posedge sys_clk) disable iff (!reset_n)
    cause_read && cause_event == 8'h00 |=> off_state_cause_latch == 8'h00;
  endproperty
  a_cause_clear: assert property (p_cause_clear)
    else $error("cause read did not clear");

  property p_cause_hold;
    @(posedge sys_clk) disable iff (!reset_n)
    !cause_read && cause_event == 8'h00 |=> $stable(off_state_cause_latch);
  endproperty
  a_cause_hold: assert property (p_cause_hold)
    else $error("cause latch changed without cause");

  property p_early_clear;
    @(posedge sys_clk) disable iff (!reset_n)
    status_read && !cycle_end |=> !early_answer_flag;
  endproperty
  a_early_clear: assert property (p_early_clear)
    else $error("status read did not clear early flag");

  property p_early_hold;
    @(posedge sys_clk) disable iff (!reset_n)
    !status_read && !cycle_end |=> $stable(early_answer_flag);
  endproperty
  a_early_hold: assert property (p_early_hold)
    else $error("early flag changed outside cycle end");

  property p_single;
    @(posedge sys_clk) disable iff (!reset_n)
    cycle_end && watchdog_mode_select && st.resp_count != 3'h0
      |=> early_answer_flag;
  endproperty
  a_single: assert property (p_single)
    else $error("single mode early answer missed");

  property p_multi_low;
    @(posedge sys_clk) disable iff (!reset_n)
    cycle_end && !watchdog_mode_select && st.resp_count < 3'h3
      |=> !early_answer_flag;
  endproperty
  a_multi_low: assert property (p_multi_low)
    else $error("multi mode flag set with few answers");

  property p_multi_high;
    @(posedge sys_clk) disable iff (!reset_n)
    cycle_end && !watchdog_mode_select && st.resp_count >= 3'h4
      |=> early_answer_flag;
  endproperty
  a_multi_high: assert property (p_multi_high)
    else $error("multi mode flag clear with four answers");

  property p_answer;
    @(posedge sys_clk) disable iff (!reset_n)
    answer_write_command && !reset_state
      |=> answer_strobe && watchdog_answer_byte == $past(answer_byte_field);
  endproperty
  a_answer: assert property (p_answer)
    else $error("answer byte not stored");

  property p_answer_rst;
    @(posedge sys_clk) disable iff (!reset_n)
    reset_state |=> watchdog_answer_byte == 8'h00;
  endproperty
  a_answer_rst: assert property (p_answer_rst)
    else $error("answer not initialised in reset state");

  property p_answer_read;
    @(posedge sys_clk) disable iff (!reset_n)
    answer_read && !answer_write_command && !reset_state
      |=> $stable(watchdog_answer_byte) && !answer_strobe;
  endproperty
  a_answer_read: assert property (p_answer_read)
    else $error("answer read changed answer register");

  c_early: cover property (@(posedge sys_clk) disable iff (!reset_n)
    cycle_end ##1 early_answer_flag);
  c_cause: cover property (@(posedge sys_clk) disable iff (!reset_n)
    cause_event != 8'h00 ##1 cause_read);
  c_answer: cover property (@(posedge sys_clk) disable iff (!reset_n)
    answer_write_command ##1 answer_write_command);
  c_clear: cover property (@(posedge sys_clk) disable iff (!reset_n)
    early_answer_flag && status_read && !cycle_end);

endmodule : wdar_regs
`default_nettype wire

/* wdar_mcu.sv */
// Processor model issuing serial register commands
`timescale 1ns/1ns
`default_nettype none
module wdar_mcu (
  // Clock
  input  wire logic  sys_clk,
  // Commands
  output logic       wr,
  output logic [7:0] data,
  output logic       st_rd,
  output logic       ca_rd,
  output logic       an_rd
);
  initial {wr, data, st_rd, ca_rd, an_rd} = 12'h000;
  // One command set per falling edge
  task automatic step(input logic [11:0] c);
    @(negedge sys_clk);
    {wr, data, st_rd, ca_rd, an_rd} = c;
  endtask : step
endmodule : wdar_mcu
`default_nettype wire

/* test_wdar_regs.sv */
// Bench for the watchdog answer and off-state cause registers
`timescale 1ns/1ns
`default_nettype none
`include "wdar_map.svh"
module test_wdar_regs;
  logic                  sys_clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  rst_st  = 1'b0;
  logic                  mode    = 1'b0;
  logic                  rw1     = 1'b0;
  logic                  clw     = 1'b0;
  logic                  ce      = 1'b0;
  logic                  wr, st_rd, ca_rd, an_rd, flag, stb, m_flag, m_stb;
  logic [7:0]            data, ans, cau, ard, m_ans, m_cau;
  wdar_pkg::wdar_cause_t cev = 8'h00;
  logic [31:0]           r = 32'h9429;
  int                    cnt, cin, nw, fails, total_checks;

  always #4 sys_clk = ~sys_clk;
  wdar_mcu mcu (.sys_clk(sys_clk), .wr(wr), .data(data), .st_rd(st_rd),
    .ca_rd(ca_rd), .an_rd(an_rd));
  wdar_regs dut (.sys_clk(sys_clk), .reset_n(reset_n), .reset_state(rst_st),
    .watchdog_mode_select(mode), .resp_window1(rw1), .close_window(clw),
    .cycle_end(ce), .answer_write_command(wr), .answer_byte_field(data),
    .status_read(st_rd), .cause_read(ca_rd), .answer_read(an_rd),
    .cause_event(cev), .early_answer_flag(flag),
    .watchdog_answer_byte(ans), .answer_strobe(stb),
    .off_state_cause_latch(cau), .answer_read_data(ard));

  // Reference model
  always @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 0;
      m_flag <= `WDAR_EARLY_RST;
      m_ans <= `WDAR_ANSWER_RST;
      m_stb <= 1'b0;
      m_cau <= `WDAR_CAUSE_RST;
    end else begin
      cin = cnt + int'(wr && (mode ? clw : rw1));
      cnt <= ce ? 0 : cin;
      if (ce)
        m_flag <= mode ? cin != 0 : cin >= `WDAR_MULTI_COUNT;
      else if (st_rd)
        m_flag <= 1'b0;
      m_stb <= wr;
      m_ans <= rst_st ? `WDAR_ANSWER_RST : (wr ? data : m_ans);
      m_cau <= (ca_rd ? 8'h00 : m_cau) | cev;
    end
  end

  task automatic check(input string n, input logic [7:0] s, e);
    total_checks++;
    if (s !== e) begin
      fails++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : check

  always @(negedge sys_clk) begin
    check("flag", {7'h00, flag}, {7'h00, m_flag});
    check("answer", ans, m_ans);
    check("strobe", {7'h00, stb}, {7'h00, m_stb});
    check("cause", cau, m_cau);
    check("cause hi", {4'h0, cau[7:4]}, {4'h0, m_cau[7:4]});
    check("cause hi", {4'h0, cau[7:4]}, {4'h0, m_cau[7:4]});
    check("cause lo", {4'h0, cau[3:0]}, {4'h0, m_cau[3:0]});
    check("cause lo", {4'h0, cau[3:0]}, {4'h0, m_cau[3:0]});
    check("read data", ard, 8'h00);
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction : xs

  // One clock of a watchdog cycle; slot 7 ends it
  task automatic cyc(input int i, k);
    r = xs(r);
    if (i == 0)
      nw = (k == 0 || k == 31) ? 0 :
           (r[0] ? int'(r[1]) : int'(r[3:1]));
    mcu.step({i < nw || i == 6, r[7:0], r[8] & r[9], r[10] & r[11], r[12]});
    if (i == 0)
      mode = r[0];
    rw1 = mode ? r[13] : i < 6;
    clw = mode ? i < 6 : r[13];
    ce = i == 7;
    rst_st = i == 7 && r[14] && r[15];
    cev = r[23:16] & r[31:24] & {8{r[16]}};
  endtask : cyc

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  initial begin
    #20000;
    fails++;
    stop_test();
  end

  initial begin
    repeat (8) @(negedge sys_clk);
    reset_n = 1'b1;
    $display("test reset done");
    for (int k = 0; k < 60; k++) begin
      for (int i = 0; i < 8; i++)
        cyc(i, k);
      if (k == 30) begin
        cyc(8, 1);
        reset_n = 1'b0;
        cyc(8, 1);
        reset_n = 1'b1;
        $display("test mid reset done");
      end
    end
    $display("test random cycles done");
    stop_test();
  end
endmodule : test_wdar_regs
`default_nettype wire
